// *** test/sdram_chip_model.sv ***
`timescale 1ns/1ps
module sdram_chip_model
    import sdram_fv_pkg::*;
(
    // control from bench
    input  wire logic        rst_n_i,
    input  wire logic        wide_i,
    input  wire integer      bad_idx_i,
    input  wire logic [31:0] bad_mask_i,
    // memory pins
    input  wire logic        mem_clk_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [1:0]  ba_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [3:0]  dqm_i,
    input  wire logic [31:0] dq_i,
    output logic      [31:0] dq_o,
    // bookkeeping
    output int               n_wr_o,
    output int               n_wr_rd_o,
    output int               n_perr_o
);
    logic [31:0] mem [logic [22:0]];
    logic [11:0] row_r [4];
    logic [31:0] rd_r, lm;
    logic [22:0] key;
    int          n_rd, rd_cnt;
    assign lm = {{8{!dqm_i[3]}}, {8{!dqm_i[2]}}, {8{!dqm_i[1]}}, {8{!dqm_i[0]}}};
    assign key = {ba_i, row_r[ba_i], addr_i[8:0] & (wide_i ? 9'h0ff : 9'h1ff)};
    // outside the data window the bus shows the inverse, never a kind value
    assign dq_o = rd_cnt > 0 ? rd_r : ~rd_r;

    always @(posedge mem_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem.delete();
            n_rd = 0;
            rd_cnt = 0;
            rd_r = 32'h0;
            n_wr_o = 0;
            n_wr_rd_o = -1;
            n_perr_o = 0;
        end else begin
            if (rd_cnt > 0) rd_cnt--;
            case ({cs_n_i, ras_n_i, cas_n_i, we_n_i})
                CMD_ACT: row_r[ba_i] = addr_i;
                CMD_WRITE: begin
                    if (((dq_i ^ 32'(n_wr_o)) & lm) != 32'h0) n_perr_o++;
                    // masked lanes keep garbage
                    mem[key] = dq_i ^ ~lm;
                    n_wr_o++;
                end
                CMD_READ: begin
                    if (n_rd == 0) n_wr_rd_o = n_wr_o;
                    rd_r = mem.exists(key) ? mem[key] : 32'hffffffff;
                    if (n_rd == bad_idx_i) rd_r = rd_r ^ bad_mask_i;
                    n_rd++;
                    rd_cnt = CAS_LAT + 1;
                end
                default: ;
            endcase
        end
    end
endmodule

// *** test/sdram_fv_asserts.sv ***
`timescale 1ns/1ps
module sdram_fv_asserts
    import sdram_fv_pkg::*;
#(
    parameter int POWERUP_SLOTS = 4,
    parameter int ROW_COUNT     = 1
) (
    // clock, reset, straps
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        wide_bus_i,
    input  wire logic        alt_type_i,
    // status
    input  wire logic        busy_o,
    input  wire logic        pass_o,
    input  wire logic        fail_o,
    // memory pins
    input  wire logic        memory_side_clock_o,
    input  wire logic        cs_n_o,
    input  wire logic        ras_n_o,
    input  wire logic        cas_n_o,
    input  wire logic        we_n_o,
    input  wire logic [11:0] addr_o,
    input  wire logic [3:0]  dqm_o,
    input  wire logic        cke_o,
    input  wire logic        dq_oe_o
);
    logic [3:0]  cmd;
    logic        slot;
    logic [15:0] pre_r, act_r, ref_r, wr_r;
    logic [1:0]  nref_r;
    int          t_rfc, t_ref;
    assign cmd   = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
    assign slot  = !memory_side_clock_o;
    assign t_rfc = wide_bus_i ? TRFC32_CYC : alt_type_i ? TRFCA_CYC : TRFC16_CYC;
    assign t_ref = wide_bus_i ? TREF32_CYC : TREF16_CYC;

    function automatic logic [15:0] nx(input logic hit, input logic [15:0] v);
        return hit ? 16'h0 : (v == 16'hffff ? v : v + 16'h1);
    endfunction

    // =========================================
    // slots since each precharge, activate, refresh and write
    // =========================================
    // counters start saturated so the first precharge-all is not flagged
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_r  <= 16'hffff;
            act_r  <= 16'hffff;
            ref_r  <= 16'hffff;
            wr_r   <= 16'hffff;
            nref_r <= 2'h0;
        end else if (slot) begin
            pre_r  <= nx(cmd == CMD_PRE, pre_r);
            act_r  <= nx(cmd == CMD_ACT, act_r);
            ref_r  <= nx(cmd == CMD_REF, ref_r);
            wr_r   <= nx(cmd == CMD_WRITE, wr_r);
            if (cmd == CMD_REF && nref_r != 2'h3) begin
                nref_r <= nref_r + 2'h1;
            end
        end
    end

    // =========================================
    // checks
    // =========================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence issue_s(logic [3:0] c);
        slot && cmd == c;
    endsequence
    sequence any_s;
        slot && cmd != CMD_NOP;
    endsequence

    ref_gap_a: assert property (
        any_s |-> ref_r + 1 >= t_rfc) else $error("command too soon after refresh");
    pre_act_a: assert property (
        issue_s(CMD_ACT) |-> pre_r + 1 >= TRP16_CYC) else $error("activate too soon");
    row_open_a: assert property (
        issue_s(CMD_PRE) |-> act_r + 1 >= (wide_bus_i ? TRAS32_CYC : TRAS16_CYC))
        else $error("precharge too soon after activate");
    act_rw_a: assert property (
        issue_s(CMD_READ) or issue_s(CMD_WRITE) |-> act_r + 1 >= TRCD16_CYC)
        else $error("access too soon after activate");
    wr_rec_a: assert property (
        issue_s(CMD_PRE) |-> wr_r + 1 >= TWR16_CYC)
        else $error("precharge too soon after write");
    ref_due_a: assert property (
        slot && busy_o && nref_r >= 2'h2 |-> ref_r < t_ref + 8)
        else $error("refresh overdue");
    mode_set_a: assert property (
        issue_s(CMD_MRS) |-> nref_r == 2'h2 && addr_o == MODE_WORD)
        else $error("mode write out of order or wrong word");
    // lane masks and drive enables
    // straps land one edge after release, so skip that first slot
    lane_mask_a: assert property (
        slot && $past(arst_n_i) |-> dqm_o == (wide_bus_i ? 4'h0 : 4'hc))
        else $error("bad lane mask");
    drive_en_a: assert property (
        slot |-> cke_o && dq_oe_o == (cmd == CMD_WRITE))
        else $error("bad drive enable");
    // commands stand a whole memory clock
    cmd_hold_a: assert property (
        memory_side_clock_o |-> $stable(cmd)) else $error("command changed mid slot");
    verdict_a: assert property (
        $fell(busy_o) |-> (pass_o ^ fail_o) ##1 (!busy_o && $stable(pass_o)))
        else $error("bad verdict at end");
    early_pass_a: assert property (
        busy_o |-> !pass_o) else $error("pass before end");
endmodule

bind sdram_fill_verify_controller sdram_fv_asserts #(
    .POWERUP_SLOTS(POWERUP_SLOTS), .ROW_COUNT(ROW_COUNT)
) u_asserts (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .wide_bus_i(wide_bus_i),
    .alt_type_i(alt_type_i), .busy_o(busy_o), .pass_o(pass_o),
    .fail_o(fail_o), .memory_side_clock_o(memory_side_clock_o),
    .cs_n_o(cs_n_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
    .addr_o(addr_o), .dqm_o(dqm_o), .cke_o(cke_o), .dq_oe_o(dq_oe_o)
);

// *** test/test_sdram_fill_verify_controller.sv ***
`timescale 1ns/1ps
module test_sdram_fill_verify_controller;
    import sdram_fv_pkg::*;
    localparam int ROWS_SIM = 1;
    logic        clk, arst_n, wide, alt, busy, pass, fail, msc;
    logic        cs_n, ras_n, cas_n, we_n, dq_oe;
    logic [1:0]  ba;
    logic [11:0] addr;
    logic [3:0]  dqm;
    logic [31:0] dq_w, dq_r, bad_mask;
    int          bad_idx, n_wr, n_wr_rd, n_perr, n_done;
    int          n_mismatch, check_count;
    bit          exp_fail_q[$];
    int          exp_area_q[$];

    sdram_fill_verify_controller #(.POWERUP_SLOTS(4), .ROW_COUNT(ROWS_SIM)) DUT (
        .clk_i(clk), .arst_n_i(arst_n), .wide_bus_i(wide), .alt_type_i(alt),
        .busy_o(busy), .pass_o(pass), .fail_o(fail),
        .memory_side_clock_o(msc), .cke_o(), .cs_n_o(cs_n), .ras_n_o(ras_n),
        .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr),
        .dqm_o(dqm), .dq_o(dq_w), .dq_oe_o(dq_oe), .dq_i(dq_r));

    sdram_chip_model mem (
        .rst_n_i(arst_n), .wide_i(wide), .bad_idx_i(bad_idx),
        .bad_mask_i(bad_mask), .mem_clk_i(msc), .cs_n_i(cs_n),
        .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba),
        .addr_i(addr), .dqm_i(dqm), .dq_i(dq_w), .dq_o(dq_r),
        .n_wr_o(n_wr), .n_wr_rd_o(n_wr_rd), .n_perr_o(n_perr));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // =========================================
    // compare and close
    // =========================================
    task automatic check_flag(string what, logic exp, logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_num(string what, int exp, int got);
        check_count++;
        if (got != exp) begin
            n_mismatch++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // =========================================
    // one fill and verify pass per call
    // =========================================
    // a fail run is cut short by the next reset, or by results after the last run, which keeps the run brief
    task automatic run(logic w, logic a, int idx, logic [31:0] m);
        int done0;
        done0 = n_done;
        @(posedge clk);
        arst_n   <= 1'b0;
        wide     <= w;
        alt      <= a;
        bad_idx  <= idx;
        bad_mask <= m;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        exp_fail_q.push_back((m & (w ? 32'hffffffff : 32'h0000ffff)) != 0);
        exp_area_q.push_back(4 * ROWS_SIM * (w ? COLS32 : COLS16));
        wait (n_done == done0 + 1);
    endtask

    initial begin
        bit e;
        n_done = 0;
        forever begin
            @(negedge clk);
            if (arst_n === 1'b1 && exp_fail_q.size() > 0
                && (busy === 1'b0 || fail === 1'b1)) begin
                e = exp_fail_q.pop_front();
                check_flag("fail_o", e, fail);
                check_flag("pass_o", !e, pass);
                check_flag("busy_o", e, busy);
                check_num("words before read", exp_area_q.pop_front(), n_wr_rd);
                check_num("fill pattern errors", 0, n_perr);
                n_done++;
            end
        end
    end

    initial begin
        arst_n = 1'b0;
        wide = 1'b0;
        alt = 1'b0;
        bad_idx = -1;
        bad_mask = 32'h0;
        n_mismatch = 0;
        check_count = 0;
        void'($urandom(57));
        // upper lanes are not compared in 16-bit mode
        run(1'b0, 1'b0, $urandom_range(2047), {16'($urandom) | 16'h1, 16'h0});
        run(1'b0, 1'b1, $urandom_range(63), 32'h1 << $urandom_range(15));
        run(1'b1, 1'b0, $urandom_range(63), 32'h1 << $urandom_range(31));
        results();
    end

    initial begin
        #(100 * 110000);
        n_mismatch++;
        results();
    end
endmodule

// *** verilog/sdram_fill_verify_controller.sv ***
//
// Operation
// RULE1: after reset, initialise the memory then fill it with a count.
// RULE2: read the area back word by word only after the fill is done.
// RULE3: compare each word with the count, flag pass or fail.
// RULE4: four banks, 12-bit rows, 16-bit/9-bit or 32-bit/8-bit cols.
// RULE5: 4096 auto-refreshes within each 64 ms. No refresh is issued once ST_DONE is reached.
// RULE6: no command within 60 ns after an auto-refresh.
// RULE7: the alternative 16-bit type waits 63 ns after auto-refresh.
// RULE8: 18 ns from precharge to activate in that bank.
// RULE9: a row stays open 42 ns before its precharge.
// RULE10: 18 ns from activate to read or write.
// RULE11: one memory clock plus 6 ns (7 ns wide) after write data.
// RULE12: counts derive from a 60 MHz or 80 MHz memory clock.
// RULE13: every minimum time rounds up to whole memory clocks.
// RULE14: two auto-refreshes before the mode write, CAS latency 2.
//
`timescale 1ns/1ps

module sdram_fv_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;

    assign in_ready_o  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_ptr_r != rd_ptr_r;
    assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (in_valid_i && in_ready_o) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (in_valid_i && in_ready_o) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (out_valid_o && out_ready_i) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

module sdram_fill_verify_controller
    import sdram_fv_pkg::*;
#(
    parameter int POWERUP_SLOTS = sdram_fv_pkg::POWERUP_CYC,
    parameter int ROW_COUNT     = sdram_fv_pkg::ROWS
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // memory type straps
    input  wire logic        wide_bus_i,
    input  wire logic        alt_type_i,
    // status
    output logic             busy_o,
    output logic             pass_o,
    output logic             fail_o,
    // memory pins
    output logic             memory_side_clock_o,
    output logic             cke_o,
    output logic             cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic [1:0]       ba_o,
    output logic [11:0]      addr_o,
    output logic [3:0]       dqm_o,
    output logic [31:0]      dq_o,
    output logic             dq_oe_o,
    input  wire logic [31:0] dq_i
);
    import sdram_fv_pkg::*;

    typedef enum logic [8:0] {
        ST_POWERUP  = 9'h001,
        ST_PRE_ALL  = 9'h002,
        ST_INIT_REF = 9'h004,
        ST_MRS      = 9'h008,
        ST_IDLE     = 9'h010,
        ST_RW       = 9'h020,
        ST_CAP      = 9'h040,
        ST_PRE      = 9'h080,
        ST_DONE     = 9'h100
    } state_type;

    function automatic logic [11:0] pick(input logic w, input int a,
                                         input int b);
        return w ? 12'(b - 1) : 12'(a - 1);
    endfunction

    state_type    state_r;
    logic         div_r;
    logic         wide_r;
    logic         alt_r;
    logic [15:0]  pwr_r;
    logic [11:0]  wait_r;
    logic [11:0]  ras_r;
    logic [11:0]  ref_cnt_r;
    logic         ref_pend_r;
    logic         init_ref_r;
    logic         reading_r;
    logic [8:0]   col_r;
    logic [11:0]  row_r;
    logic [1:0]   bank_r;
    logic [31:0]  gen_r;
    logic [31:0]  exp_r;
    logic         fail_r;
    logic [3:0]   cmd_r;
    logic         slot;
    logic         go;
    logic         last_col;
    logic         last;
    logic         ref_set;
    logic         ref_clr;
    logic         fifo_valid;
    logic         fifo_ready;
    logic         gen_ready;
    logic [31:0]  fifo_data;
    logic [31:0]  mask;
    logic [11:0]  trfc;
    logic [11:0]  trp;

    // =========================================
    // memory clock and timing selection
    // =========================================
    // RULE12: one slot per memory clock
    assign slot = div_r;
    assign go   = slot && (wait_r == 12'h000);
    assign memory_side_clock_o = div_r;
    // RULE7: alternative type
    assign trfc = alt_r ? pick(1'b0, TRFCA_CYC, TRFCA_CYC)
                        : pick(wide_r, TRFC16_CYC, TRFC32_CYC);
    assign trp  = pick(wide_r, TRP16_CYC, TRP32_CYC);
    assign mask = wide_r ? 32'hffffffff : 32'h0000ffff;
    // RULE4: column width by type
    assign last_col = wide_r ? (col_r == 9'(COLS32 - 1))
                             : (col_r == 9'(COLS16 - 1));
    assign last = last_col && (bank_r == 2'h3)
               && (row_r == 12'(ROW_COUNT - 1));

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_r <= 1'b0;
        end else begin
            div_r <= !div_r;
        end
    end

    // straps caught while the power-up wait runs
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wide_r <= 1'b0;
            alt_r  <= 1'b0;
        end else if (state_r == ST_POWERUP) begin
            wide_r <= wide_bus_i;
            alt_r  <= alt_type_i && !wide_bus_i;
        end
    end

    // =========================================
    // refresh interval
    // =========================================
    assign ref_set = slot && (ref_cnt_r == 12'h000);
    assign ref_clr = go && (state_r == ST_IDLE) && ref_pend_r;

    // RULE5: refresh scheduling
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_cnt_r  <= 12'h000;
            ref_pend_r <= 1'b0;
        end else if (state_r != ST_POWERUP) begin
            if (slot) begin
                ref_cnt_r <= (ref_cnt_r == 12'h000)
                    ? pick(wide_r, TREF16_CYC, TREF32_CYC)
                    : ref_cnt_r - 12'h001;
            end
            // a new request wins over the clear
            ref_pend_r <= ref_set || (ref_pend_r && !ref_clr);
        end
    end

    // =========================================
    // pattern source through the fifo
    // =========================================
    assign gen_ready = fifo_ready;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gen_r <= 32'h00000000;
        end else if (!reading_r && gen_ready) begin
            gen_r <= gen_r + 32'h00000001;
        end
    end

    sdram_fv_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (!reading_r),
        .in_ready_o  (fifo_ready),
        .in_data_i   (gen_r),
        .out_valid_o (fifo_valid),
        .out_ready_i (go && (state_r == ST_RW) && !reading_r),
        .out_data_o  (fifo_data)
    );

    // =========================================
    // command sequencer
    // =========================================
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r    <= ST_POWERUP;
            cmd_r      <= CMD_NOP;
            ba_o       <= 2'h0;
            addr_o     <= 12'h000;
            dq_o       <= 32'h00000000;
            dq_oe_o    <= 1'b0;
            wait_r     <= 12'h000;
            ras_r      <= 12'h000;
            pwr_r      <= 16'(POWERUP_SLOTS);
            init_ref_r <= 1'b0;
        end else if (slot) begin
            cmd_r   <= CMD_NOP;
            dq_oe_o <= 1'b0;
            if (wait_r != 12'h000) begin
                wait_r <= wait_r - 12'h001;
            end
            if (ras_r != 12'h000) begin
                ras_r <= ras_r - 12'h001;
            end
            if (wait_r == 12'h000) begin
                unique case (state_r)
                    ST_POWERUP: begin
                        if (pwr_r == 16'h0000) begin
                            state_r <= ST_PRE_ALL;
                        end else begin
                            pwr_r <= pwr_r - 16'h0001;
                        end
                    end
                    ST_PRE_ALL: begin
                        cmd_r  <= CMD_PRE;
                        addr_o <= 12'(1 << ADDR_PRE_ALL);
                        wait_r <= trp;
                        state_r <= ST_INIT_REF;
                    end
                    // RULE14: two refreshes then mode
                    ST_INIT_REF: begin
                        cmd_r      <= CMD_REF;
                        wait_r     <= trfc;
                        init_ref_r <= 1'b1;
                        if (init_ref_r) begin
                            state_r <= ST_MRS;
                        end
                    end
                    ST_MRS: begin
                        cmd_r   <= CMD_MRS;
                        ba_o    <= 2'h0;
                        addr_o  <= MODE_WORD;
                        wait_r  <= 12'(TMRD_CYC - 1);
                        state_r <= ST_IDLE;
                    end
                    ST_IDLE: begin
                        // RULE6: refresh period
                        if (ref_pend_r) begin
                            cmd_r  <= CMD_REF;
                            wait_r <= trfc;
                        end else if (reading_r || fifo_valid) begin
                            // RULE10: activate to access
                            cmd_r   <= CMD_ACT;
                            ba_o    <= bank_r;
                            addr_o  <= row_r;
                            wait_r  <= pick(wide_r, TRCD16_CYC,
                                            TRCD32_CYC);
                            ras_r   <= pick(wide_r, TRAS16_CYC,
                                            TRAS32_CYC);
                            state_r <= ST_RW;
                        end
                    end
                    ST_RW: begin
                        addr_o <= {3'h0, col_r};
                        if (reading_r) begin
                            cmd_r   <= CMD_READ;
                            wait_r  <= 12'(CAS_LAT - 1);
                            state_r <= ST_CAP;
                        end else begin
                            // RULE11: write recovery
                            cmd_r   <= CMD_WRITE;
                            dq_o    <= fifo_data;
                            dq_oe_o <= 1'b1;
                            wait_r  <= pick(wide_r, TWR16_CYC,
                                            TWR32_CYC);
                            state_r <= ST_PRE;
                        end
                    end
                    ST_CAP: begin
                        state_r <= ST_PRE;
                    end
                    // RULE9: row open time
                    ST_PRE: begin
                        if (ras_r == 12'h000) begin
                            cmd_r   <= CMD_PRE;
                            addr_o  <= 12'h000;
                            // RULE8: precharge period
                            wait_r  <= trp;
                            state_r <= (last && reading_r) ? ST_DONE
                                                           : ST_IDLE;
                        end
                    end
                    ST_DONE: begin
                        cmd_r <= CMD_NOP;
                    end
                endcase
            end
        end
    end

    assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_r;
    assign cke_o = 1'b1;
    assign dqm_o = wide_r ? 4'h0 : 4'hc;

    // =========================================
    // address walk and phase
    // =========================================
    // RULE2: read only after full fill
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            col_r     <= 9'h000;
            row_r     <= 12'h000;
            bank_r    <= 2'h0;
            reading_r <= 1'b0;
        end else if (go && (state_r == ST_PRE) && (ras_r == 12'h000)) begin
            if (last) begin
                col_r     <= 9'h000;
                row_r     <= 12'h000;
                bank_r    <= 2'h0;
                reading_r <= 1'b1;
            end else if (last_col) begin
                col_r <= 9'h000;
                if (row_r == 12'(ROW_COUNT - 1)) begin
                    row_r  <= 12'h000;
                    bank_r <= bank_r + 2'h1;
                end else begin
                    row_r <= row_r + 12'h001;
                end
            end else begin
                col_r <= col_r + 9'h001;
            end
        end
    end

    // =========================================
    // verify
    // =========================================
    // RULE3: compare with expected count
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            exp_r  <= 32'h00000000;
            fail_r <= 1'b0;
        end else if (go && (state_r == ST_CAP)) begin
            exp_r <= exp_r + 32'h00000001;
            if (((dq_i ^ exp_r) & mask) != 32'h00000000) begin
                fail_r <= 1'b1;
            end
        end
    end

    // RULE1: busy until fill and verify end
    assign busy_o = state_r != ST_DONE;
    assign pass_o = (state_r == ST_DONE) && !fail_r;
    assign fail_o = fail_r;
endmodule

// *** verilog/sdram_fv_pkg.sv ***
package sdram_fv_pkg;
    // =========================================
    // memory clock rates and minimum times
    // =========================================
    localparam int MEM16_MHZ     = 60;
    localparam int MEM32_MHZ     = 80;
    localparam int TRFC_NS       = 60;
    localparam int TRFC_ALT_NS   = 63;
    localparam int TRP_NS        = 18;
    localparam int TRAS_NS       = 42;
    localparam int TRCD_NS       = 18;
    localparam int TWR16_NS      = 6;
    localparam int TWR32_NS      = 7;
    localparam int REF_PERIOD_MS = 64;
    localparam int REF_ROWS      = 4096;
    localparam int REF_INT_NS    = REF_PERIOD_MS * 1000000 / REF_ROWS;
    localparam int POWERUP_US    = 100;
    localparam int TMRD_CYC      = 2;
    localparam int INIT_REFS     = 2;
    localparam int CAS_LAT       = 2;

    // RULE13: round up to clocks
    function automatic int ceil_cyc(input int ns, input int mhz);
        return (ns * mhz + 999) / 1000;
    endfunction

    localparam int TRFC16_CYC = ceil_cyc(TRFC_NS, MEM16_MHZ);
    localparam int TRFC32_CYC = ceil_cyc(TRFC_NS, MEM32_MHZ);
    localparam int TRFCA_CYC  = ceil_cyc(TRFC_ALT_NS, MEM16_MHZ);
    localparam int TRP16_CYC  = ceil_cyc(TRP_NS, MEM16_MHZ);
    localparam int TRP32_CYC  = ceil_cyc(TRP_NS, MEM32_MHZ);
    localparam int TRAS16_CYC = ceil_cyc(TRAS_NS, MEM16_MHZ);
    localparam int TRAS32_CYC = ceil_cyc(TRAS_NS, MEM32_MHZ);
    localparam int TRCD16_CYC = ceil_cyc(TRCD_NS, MEM16_MHZ);
    localparam int TRCD32_CYC = ceil_cyc(TRCD_NS, MEM32_MHZ);
    localparam int TWR16_CYC  = 1 + ceil_cyc(TWR16_NS, MEM16_MHZ);
    localparam int TWR32_CYC  = 1 + ceil_cyc(TWR32_NS, MEM32_MHZ);
    localparam int TREF16_CYC = REF_INT_NS * MEM16_MHZ / 1000;
    localparam int TREF32_CYC = REF_INT_NS * MEM32_MHZ / 1000;
    localparam int POWERUP_CYC = POWERUP_US * MEM16_MHZ;

    // =========================================
    // geometry and data path
    // =========================================
    localparam int ROWS        = 4096;
    localparam int COLS16      = 512;
    localparam int COLS32      = 256;
    localparam int DATA_W      = 32;
    localparam int FIFO_DEPTH  = 16;
    localparam int ADDR_PRE_ALL = 10;

    // =========================================
    // commands {cs_n, ras_n, cas_n, we_n}
    // =========================================
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_MRS   = 4'h0;

    // burst length 1, sequential, single write
    localparam logic [11:0] MODE_WORD = 12'(CAS_LAT << 4);
endpackage
